// ===== hdl/sadc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
`define SADC_OFF_SEL      32'h0000_0000
`define SADC_OFF_CTRL     32'h0000_0004
`define SADC_OFF_RESULT   32'h0000_0008
`define SADC_OFF_SLEEP    32'h0000_000c
`define SADC_CTL_PS_LSB   0
`define SADC_CTL_IE       3
`define SADC_CTL_FLAG     4
`define SADC_CTL_AUTO     5
`define SADC_CTL_START    6
`define SADC_CTL_EN       7
`define SADC_CTL_FREE     8
`define SADC_SEL_REF      6
`define SADC_SEL_RST      8'h00
`define SADC_CTL_RST      9'h000
// conversion lengths and sample points in half converter cycles; trigger delay in system clock cycles
`define SADC_HC_FIRST     8'd50
`define SADC_HC_FIRST_SH  8'd27
`define SADC_HC_NORM      8'd26
`define SADC_HC_NORM_SH   8'd3
`define SADC_HC_AUTO      8'd27
`define SADC_HC_AUTO_SH   8'd4
`define SADC_HC_FREE      8'd28
`define SADC_HC_FREE_SH   8'd5
`define SADC_TRIG_SYNC    2'd3
`endif

// ===== hdl/sadc_pkg.sv
// types shared by the sequencer
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_KIND_FIRST,
		SADC_KIND_NORM,
		SADC_KIND_AUTO,
		SADC_KIND_FREE
	} sadc_kind_t;
endpackage

// ===== hdl/sadc_prescaler.sv
// converter clock prescaler giving half-cycle enable pulses
`timescale 1ns/100ps
module sadc_prescaler #(
	parameter int WIDTH = 7
) (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_clear,
	input  wire logic [2:0] i_sel,
	output logic            o_rise,
	output logic            o_fall
);
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] half_w;
	logic [WIDTH-1:0] full_w;
	logic [WIDTH-1:0] sh_w;

	// code 0 and 1 divide by 2, codes 2..7 by 4..128
	assign sh_w   = (i_sel == 3'd0) ? WIDTH'(0) : WIDTH'(i_sel - 3'd1);
	assign full_w = WIDTH'((WIDTH'(1) << sh_w) * 2 - 1);
	assign half_w = WIDTH'(1) << sh_w;
	assign o_fall = !i_clear && (cnt_r == half_w - WIDTH'(1));
	assign o_rise = !i_clear && (cnt_r == full_w);

	// counter held in reset while cleared
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			cnt_r <= '0;
		else if (i_clear || o_rise)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + WIDTH'(1);
	end
endmodule // sadc_prescaler

// ===== hdl/sadc_sequencer.sv
// successive approximation converter sequencer with ahb-lite registers
// Behaviour
// - prescaler runs while enable set, held reset while enable low
// - single start begins at next converter clock rising edge
// - normal conversion 13 cycles, sample-and-hold at 1.5
// - first conversion after enable 25 cycles, sample at 13.5
// - completion loads result and sets complete flag same cycle
// - single mode clears start bit with flag; new write restarts
// - auto trigger event resets the prescaler
// - auto conversion samples at 2 cycles, total 13.5 cycles
// - trigger passes three system clock synchroniser stages
// - free running restarts at completion, start bit stays high
// - holding selection copied to active selection while idle
// - active selection frozen during conversion, resumes last cycle
// - free-running selection change during a conversion affects the next conversion
// - idle/noise sleep starts conversion when processor halts
// - sleep-started conversion still raises completion request
// - other sleep modes do not disable the converter
// - further trigger edges ignored while converting
// - clearing enable terminates conversion at once
// - writing zero to start bit has no effect
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_sequencer (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic [31:0]      o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp,
	input  wire logic        i_trigger,
	input  wire logic        i_sleep_quiet,
	input  wire logic [9:0]  i_core_result,
	output logic             o_core_enable,
	output logic             o_core_sample,
	output logic [2:0]       o_channel_select,
	output logic             o_reference_select,
	output logic             o_busy,
	output logic             o_conv_complete_irq
);
	logic [7:0]  input_select_reg_r;
	logic [8:0]  ctl_r;
	logic [9:0]  result_r;
	logic [2:0]  act_chan_r;
	logic        act_ref_r;
	logic        busy_r;
	logic        inited_r;
	logic [7:0]  hc_r;
	logic [7:0]  hc_len_r;
	logic [7:0]  hc_sh_r;
	logic        pend_single_r;
	logic        pend_auto_r;
	logic [1:0]  trig_wait_r;
	logic [2:0]  trig_sync_r;
	logic        sleep_d_r;
	logic        wr_ph_r;
	logic        rd_ph_r;
	logic [3:0]  ph_addr_r;
	sadc_pkg::sadc_kind_t kind_r;

	wire logic conv_enable        = ctl_r[`SADC_CTL_EN];
	wire logic start_conversion   = ctl_r[`SADC_CTL_START];
	wire logic auto_trigger_enable = ctl_r[`SADC_CTL_AUTO];
	wire logic free_run           = ctl_r[`SADC_CTL_FREE];
	wire logic conv_complete_flag = ctl_r[`SADC_CTL_FLAG];
	wire logic [2:0] prescale_select = ctl_r[2:0];

	// bus decode; the slave always answers in zero wait states
	wire logic addr_ph = i_hsel && i_hready && i_htrans[1];
	wire logic wr_sel  = wr_ph_r && ph_addr_r == 4'(`SADC_OFF_SEL);
	wire logic wr_ctl  = wr_ph_r && ph_addr_r == 4'(`SADC_OFF_CTRL);
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

	// prescaler pulses and trigger synchroniser
	logic ck_rise;
	logic ck_fall;
	wire logic trig_edge = trig_sync_r[1] && !trig_sync_r[2];
	wire logic trig_fire = trig_wait_r == 2'd1;
	sadc_prescaler #(.WIDTH(7)) u_presc (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_clear  (!conv_enable || trig_fire),
		.i_sel    (prescale_select),
		.o_rise   (ck_rise),
		.o_fall   (ck_fall)
	);

	// half-cycle tick while converting, end of conversion
	wire logic half_tick = ck_rise || ck_fall;
	wire logic done      = busy_r && half_tick && hc_r + 8'd1 == hc_len_r;
	wire logic sleep_go  = i_sleep_quiet && !sleep_d_r && conv_enable &&
		!busy_r && !auto_trigger_enable && ctl_r[`SADC_CTL_IE];
	wire logic free_next = done && free_run;
	wire logic go_single = pend_single_r && ck_rise && !busy_r;
	wire logic go_auto   = trig_fire && !busy_r;
	wire logic sel_track = !busy_r ||
		(half_tick && hc_r + 8'd3 >= hc_len_r);
	wire logic set_start = wr_ctl && i_hwdata[`SADC_CTL_START];

	// bus phase capture
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ph_r   <= 1'b0;
			rd_ph_r   <= 1'b0;
			ph_addr_r <= 4'h0;
		end else begin
			wr_ph_r   <= addr_ph && i_hwrite;
			rd_ph_r   <= addr_ph && !i_hwrite;
			ph_addr_r <= i_haddr[3:0];
		end
	end

	// read data comes straight from the register stores
	always_comb begin
		o_hrdata = 32'h0000_0000;
		if (rd_ph_r) begin
			case (ph_addr_r)
				4'(`SADC_OFF_SEL):    o_hrdata = {24'h0, input_select_reg_r};
				4'(`SADC_OFF_CTRL):   o_hrdata = {23'h0, ctl_r};
				4'(`SADC_OFF_RESULT): o_hrdata = {22'h0, result_r};
				default:          o_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// holding selection register; reserved bits kept zero
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			input_select_reg_r <= `SADC_SEL_RST;
		else if (wr_sel)
			input_select_reg_r <= i_hwdata[7:0] & 8'h47;
	end

	// active selection follows holding register unless frozen
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			act_chan_r <= 3'h0;
			act_ref_r  <= 1'b0;
		end else if (sel_track && !(go_single || go_auto || sleep_go)) begin
			act_chan_r <= input_select_reg_r[2:0];
			act_ref_r  <= input_select_reg_r[`SADC_SEL_REF];
		end
	end

	// trigger synchroniser and three-cycle delay
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trig_sync_r <= 3'h0;
			trig_wait_r <= 2'd0;
			sleep_d_r   <= 1'b0;
		end else begin
			trig_sync_r <= {trig_sync_r[1:0], i_trigger};
			sleep_d_r   <= i_sleep_quiet;
			if (trig_wait_r != 2'd0)
				trig_wait_r <= trig_wait_r - 2'd1;
			else if (trig_edge && auto_trigger_enable && conv_enable &&
				!busy_r && !free_run)
				trig_wait_r <= `SADC_TRIG_SYNC;
		end
	end

	// control register: software writes with hardware set and clear
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctl_r         <= `SADC_CTL_RST;
			pend_single_r <= 1'b0;
		end else begin
			if (wr_ctl) begin
				ctl_r[2:0]              <= i_hwdata[2:0];
				ctl_r[`SADC_CTL_IE]     <= i_hwdata[`SADC_CTL_IE];
				ctl_r[`SADC_CTL_AUTO]   <= i_hwdata[`SADC_CTL_AUTO];
				ctl_r[`SADC_CTL_EN]     <= i_hwdata[`SADC_CTL_EN];
				ctl_r[`SADC_CTL_FREE]   <= i_hwdata[`SADC_CTL_FREE];
				if (i_hwdata[`SADC_CTL_FLAG])
					ctl_r[`SADC_CTL_FLAG] <= 1'b0;  // write one clears
			end
			if (set_start || sleep_go) begin
				ctl_r[`SADC_CTL_START] <= 1'b1;
				pend_single_r          <= 1'b1;
			end else if (go_single)
				pend_single_r <= 1'b0;
			if (go_auto)
				ctl_r[`SADC_CTL_START] <= 1'b1;
			if (done) begin
				ctl_r[`SADC_CTL_FLAG] <= 1'b1;
				if (!free_run)
					ctl_r[`SADC_CTL_START] <= 1'b0;
			end
			if (!conv_enable && !(wr_ctl && i_hwdata[`SADC_CTL_EN])) begin
				ctl_r[`SADC_CTL_START] <= 1'b0;
				pend_single_r          <= 1'b0;
			end
		end
	end

	// conversion sequencer counting half converter cycles
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			busy_r   <= 1'b0;
			inited_r <= 1'b0;
			hc_r     <= 8'd0;
			hc_len_r <= `SADC_HC_NORM;
			hc_sh_r  <= `SADC_HC_NORM_SH;
			kind_r   <= sadc_pkg::SADC_KIND_NORM;
			result_r <= 10'h000;
		end else if (!conv_enable) begin
			busy_r   <= 1'b0;
			inited_r <= 1'b0;
			hc_r     <= 8'd0;
		end else if (go_single || go_auto || free_next) begin
			busy_r <= 1'b1;
			hc_r   <= 8'd0;
			if (done)
				result_r <= i_core_result;
			if (!inited_r) begin
				kind_r   <= sadc_pkg::SADC_KIND_FIRST;
				hc_len_r <= `SADC_HC_FIRST;
				hc_sh_r  <= `SADC_HC_FIRST_SH;
			end else if (free_next) begin
				kind_r   <= sadc_pkg::SADC_KIND_FREE;
				hc_len_r <= `SADC_HC_FREE;
				hc_sh_r  <= `SADC_HC_FREE_SH;
			end else if (go_auto) begin
				kind_r   <= sadc_pkg::SADC_KIND_AUTO;
				hc_len_r <= `SADC_HC_AUTO;
				hc_sh_r  <= `SADC_HC_AUTO_SH;
			end else begin
				kind_r   <= sadc_pkg::SADC_KIND_NORM;
				hc_len_r <= `SADC_HC_NORM;
				hc_sh_r  <= `SADC_HC_NORM_SH;
			end
			inited_r <= 1'b1;
		end else if (done) begin
			busy_r   <= 1'b0;
			result_r <= i_core_result;
		end else if (busy_r && half_tick)
			hc_r <= hc_r + 8'd1;
	end

	// outputs to the analog core and status
	assign o_core_enable       = conv_enable;
	assign o_core_sample       = busy_r && hc_r == hc_sh_r;
	assign o_channel_select    = act_chan_r;
	assign o_reference_select  = act_ref_r;
	assign o_busy              = busy_r;
	assign o_conv_complete_irq = conv_complete_flag && ctl_r[`SADC_CTL_IE];

	// completion sets flag and clears single-mode start together
	property p_done_flag;
		@(posedge i_clk) disable iff (!i_arst_n)
		done && !free_run |=> conv_complete_flag && !start_conversion;
	endproperty
	a_done_flag: assert property (p_done_flag)
		else $error("completion did not set flag and clear start");

	property p_result_load;
		@(posedge i_clk) disable iff (!i_arst_n)
		done |=> result_r == $past(i_core_result);
	endproperty
	a_result_load: assert property (p_result_load)
		else $error("result not loaded on completion");

	property p_disable_stop;
		@(posedge i_clk) disable iff (!i_arst_n)
		!conv_enable |=> !busy_r;
	endproperty
	a_disable_stop: assert property (p_disable_stop)
		else $error("conversion survived disable");

	property p_freeze;
		@(posedge i_clk) disable iff (!i_arst_n)
		busy_r && !sel_track && $past(busy_r) |=> $stable(act_chan_r);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("selection moved during conversion");

	property p_free_keep;
		@(posedge i_clk) disable iff (!i_arst_n)
		done && free_run && conv_enable |=> busy_r && start_conversion;
	endproperty
	a_free_keep: assert property (p_free_keep)
		else $error("free running did not restart");

	property p_start_edge;
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(busy_r) && !$past(free_next) && !$past(go_auto)
			|-> $past(ck_rise);
	endproperty
	a_start_edge: assert property (p_start_edge)
		else $error("single start off converter clock edge");

	property p_trig_delay;
		@(posedge i_clk) disable iff (!i_arst_n)
		trig_wait_r == `SADC_TRIG_SYNC |-> ##2 trig_fire;
	endproperty
	a_trig_delay: assert property (p_trig_delay)
		else $error("trigger delay not three cycles");

	property p_prescale_hold;
		@(posedge i_clk) disable iff (!i_arst_n)
		!conv_enable |-> !ck_rise && !ck_fall;
	endproperty
	a_prescale_hold: assert property (p_prescale_hold)
		else $error("prescaler ran while disabled");
endmodule // sadc_sequencer

// ===== tb/sadc_core_model.sv
// behavioural analog converter core answering the sample strobe
`timescale 1ns/100ps
module sadc_core_model (
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_enable,
	input  wire logic       i_sample,
	input  wire logic [2:0] i_channel,
	input  wire logic       i_reference,
	output logic [9:0]      o_result
);
	logic [9:0] held_r;
	logic [5:0] cnt_r;
	logic       smp_r;
	// code carries the frozen selection plus a running count
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			held_r <= 10'h000;
			cnt_r  <= 6'h00;
			smp_r  <= 1'b0;
		end else begin
			smp_r <= i_sample;
			if (i_sample && !smp_r) begin
				held_r <= {i_reference, i_channel, cnt_r};
				cnt_r  <= cnt_r + 6'h01;
			end
		end
	end
	// a powered-down core drives the inverted held code
	assign o_result = i_enable ? held_r : ~held_r;
endmodule // sadc_core_model

// ===== tb/sadc_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_sequencer_tb;
	logic        i_clk, i_arst_n, hsel, hwrite, trig, slp;
	logic        hready, hresp, c_en, c_smp, reference_select, busy, irq;
	logic [31:0] haddr, hwdata, rd, hrdata, s, n;
	logic [1:0]  htrans;
	logic [2:0]  hsize, sel_o;
	logic [9:0]  cres;
	int          n_fail, n_tests, a, b, t, d;

	sadc_sequencer u_sadc_sequencer (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_trigger(trig), .i_sleep_quiet(slp), .i_core_result(cres),
		.o_core_enable(c_en), .o_core_sample(c_smp),
		.o_channel_select(sel_o), .o_reference_select(reference_select),
		.o_busy(busy), .o_conv_complete_irq(irq)
	);
	sadc_core_model u_sadc_core_model (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_enable(c_en),
		.i_sample(c_smp), .i_channel(sel_o), .i_reference(reference_select),
		.o_result(cres)
	);
	// free-running system clock
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] sv, input logic [31:0] ev);
		n_tests++;
		if (sv !== ev) begin
			n_fail++;
			$display("[FAIL] %0t seen %h want %h", $time, sv, ev);
		end
	endtask
	// counts within two system clocks count as on time
	function int near(int sv, int ev);
		return (sv >= ev - 2 && sv <= ev + 2) ? ev : sv;
	endfunction
	function logic [31:0] rsel();
		return {25'h0, 1'($urandom), 3'h0, 3'($urandom)};
	endfunction
	function logic [31:0] xres(logic [31:0] v);
		return {22'h0, v[6], v[2:0], 6'h00};
	endfunction
	// one single-word transfer, address then data phase
	task bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge i_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= ad;
		hwrite <= w;
		hsize <= 3'b010;
		do begin @(posedge i_clk); k++; end while (hready !== 1'b1 && k < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge i_clk); k++; end while (hready !== 1'b1 && k < 50);
		rd = hrdata;
		if (k >= 50) begin
			n_fail++;
			stop_test;
		end
	endtask
	task rdm(input logic [31:0] ad, input logic [31:0] m,
		input logic [31:0] ev);
		bus(1'b0, ad, 32'h0);
		chk(rd & m, ev);
	endtask
	function logic ev_of(int k);
		case (k)
			0: return busy;
			1: return c_smp;
			2: return !busy;
			default: return irq;
		endcase
	endfunction
	// clocks until the chosen event rises, bounded
	task wait_ev(input int k, output int tc);
		logic p;
		p = ev_of(k);
		for (tc = 1; tc <= 3000; tc++) begin
			@(posedge i_clk);
			#1;
			if (ev_of(k) === 1'b1 && p !== 1'b1) return;
			p = ev_of(k);
		end
		n_fail++;
		$display("[FAIL] %0t wait ran out", $time);
		stop_test;
	endtask
	task first_conv(input int c);
		d = (c < 2) ? 2 : (1 << c);
		s = rsel();
		bus(1'b1, `SADC_OFF_SEL, s);
		bus(1'b1, `SADC_OFF_CTRL, 32'h0d0 | c);
		wait_ev(0, t);
		wait_ev(1, a);
		wait_ev(2, b);
		chk(near(a, 27 * d / 2), 27 * d / 2);
		chk(near(a + b, 25 * d), 25 * d);
		rdm(`SADC_OFF_CTRL, 32'h1ff, 32'h090 | c);
		rdm(`SADC_OFF_RESULT, 32'h3c0, xres(s));
		chk({reference_select, sel_o}, {s[6], s[2:0]});
		$display("test first conversion done");
	endtask
	// main sequence
	initial begin
		{i_arst_n, hsel, hwrite, trig, slp, haddr, hwdata} = '0;
		{htrans, hsize, n_fail, n_tests} = '0;
		void'($urandom(32'hce60aad8));
		repeat (20) @(posedge i_clk);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 4; i++) rdm(i * 4, 32'hffffffff, 32'h0);
		bus(1'b1, `SADC_OFF_SLEEP, $urandom);
		rdm(`SADC_OFF_SLEEP, 32'hffffffff, 32'h0);
		chk({hready, hresp}, 2'b10);
		$display("test registers done");
		first_conv(1);
		for (int c = 0; c < 8; c++) begin
			d = (c < 2) ? 2 : (1 << c);
			s = rsel();
			n = rsel();
			bus(1'b1, `SADC_OFF_SEL, s);
			bus(1'b1, `SADC_OFF_CTRL, 32'h0d0 | c);
			wait_ev(0, t);
			fork
				begin
					wait_ev(1, a);
					wait_ev(2, b);
				end
				if (c >= 4) begin
					repeat (d) @(posedge i_clk);
					bus(1'b1, `SADC_OFF_SEL, n);
					bus(1'b1, `SADC_OFF_CTRL, 32'h080 | c);
					chk(sel_o, s[2:0]);
				end
			join
			chk(near(a, 3 * d / 2), 3 * d / 2);
			chk(near(a + b, 13 * d), 13 * d);
			rdm(`SADC_OFF_CTRL, 32'h1f8, 32'h090);
			rdm(`SADC_OFF_RESULT, 32'h3c0, xres(s));
			chk(sel_o, (c >= 4) ? n[2:0] : s[2:0]);
		end
		$display("test prescale codes done");
		bus(1'b1, `SADC_OFF_CTRL, 32'h0b2);
		@(posedge i_clk);
		trig <= 1'b1;
		wait_ev(1, a);
		@(posedge i_clk);
		trig <= 1'b0;
		@(posedge i_clk);
		trig <= 1'b1;
		wait_ev(2, b);
		// three pin flops, three sync cycles, then two converter cycles
		chk(near(a, 14), 14);
		chk(near(a + 2 + b, 60), 60);
		t = 0;
		for (int i = 0; i < 80; i++) begin
			@(posedge i_clk);
			t += (busy === 1'b1);
		end
		chk(t, 0);
		trig <= 1'b0;
		$display("test auto trigger done");
		d = 8;
		s = rsel();
		n = rsel();
		bus(1'b1, `SADC_OFF_SEL, s);
		bus(1'b1, `SADC_OFF_CTRL, 32'h1db);
		wait_ev(3, t);
		repeat (d) @(posedge i_clk);
		bus(1'b1, `SADC_OFF_SEL, n);
		bus(1'b1, `SADC_OFF_CTRL, 32'h1db);
		rdm(`SADC_OFF_CTRL, 32'h040, 32'h040);
		wait_ev(3, t);
		rdm(`SADC_OFF_RESULT, 32'h3c0, xres(s));
		wait_ev(1, a);
		wait_ev(1, b);
		chk(near(b, 14 * d), 14 * d);
		rdm(`SADC_OFF_RESULT, 32'h3c0, xres(n));
		bus(1'b1, `SADC_OFF_CTRL, 32'h0);
		@(posedge i_clk);
		#1;
		chk({busy, c_en}, 2'b00);
		$display("test free running and disable done");
		first_conv(0);
		bus(1'b1, `SADC_OFF_CTRL, 32'h098);
		@(posedge i_clk);
		slp <= 1'b1;
		wait_ev(0, t);
		@(posedge i_clk);
		slp <= 1'b0;
		wait_ev(3, t);
		chk(near(t, 25), 25);
		rdm(`SADC_OFF_CTRL, 32'h010, 32'h010);
		bus(1'b1, `SADC_OFF_CTRL, 32'h098);
		@(posedge i_clk);
		#1;
		chk(irq, 1'b0);
		$display("test sleep start done");
		stop_test;
	end
endmodule // sadc_sequencer_tb
